//--- ptp_pkg.sv
// shared constants and types for the power to pulse converter
package ptp_pkg;
	localparam int SMP_W = 16;
	localparam int PWR_W = 32;
	localparam int ACC_W = 48;
	// supply monitor: digital compare of a sampled supply code
	localparam logic [11:0] SUP_ON_LVL = 12'h400;
	localparam logic [11:0] SUP_OFF_LVL = 12'h3C0;
	localparam int SUP_FILT_CNT = 64;
	// sample strobe from the 100 MHz clock
	localparam int CLK_HZ = 100_000_000;
	localparam int SMP_HZ = 450_000;
	localparam int SMP_DIV = (CLK_HZ + SMP_HZ - 1) / SMP_HZ;
	// filter shifts: lpf corner near 4.37 Hz at 450 kHz, hpf well below line
	localparam int LPF_SHIFT = 14;
	localparam int HPF_SHIFT = 12;
	// averaged output threshold exponents per rate select (2^19..2^16 scaled)
	localparam int THR_BASE = 40;
	// pulse widths on the averaged and calibration outputs, in sample periods
	localparam int AVG_PULSE_SMP = 2048;
	localparam int CAL_PULSE_SMP = 16;
	typedef enum logic [1:0] {
		PTP_RATE_0,
		PTP_RATE_1,
		PTP_RATE_2,
		PTP_RATE_3
	} ptp_rate_e;
endpackage

//--- ptp_pulse_if.sv
// pulse request bundle between accumulators and output shapers
`timescale 1ns/1ps
interface ptp_pulse_if;
	logic fire;
	logic active;
	logic [15:0] width;
	modport src (output fire, output width, input active);
	modport dst (input fire, input width, output active);
endinterface

//--- ptp_pulse_gen.sv
// stretches a fire strobe into an output pulse of programmable length
`timescale 1ns/1ps
module ptp_pulse_gen
	import ptp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic enable_i,
	ptp_pulse_if.dst pls
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic busy_ff;
	wire start = pls.fire && enable_i && !busy_ff;
	wire done = busy_ff && tick_i && (cnt_ff == 16'h0001);
	assign nxt_cnt = start ? pls.width :
		(busy_ff && tick_i) ? cnt_ff - 16'h0001 : cnt_ff;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= 16'h0000;
			busy_ff <= 1'b0;
		end else begin
			cnt_ff <= enable_i ? nxt_cnt : 16'h0000;
			busy_ff <= enable_i && (start || (busy_ff && !done));
		end
	end
	assign pls.active = busy_ff;
	// a pulse never outlives the supply gate
	a_gate_kills_pulse: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!enable_i |=> !busy_ff)
		else $error("pulse survived gate");
endmodule

//--- ptp_core.sv
// power to pulse converter: supply gate, filters, multiplier, pulses
`timescale 1ns/1ps
module ptp_core
	import ptp_pkg::*;
#(
	parameter int SMP_W_P = SMP_W,
	parameter int FILT_P = SUP_FILT_CNT
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [11:0] supply_level_i,
	input wire logic signed [SMP_W_P-1:0] current_channel_i,
	input wire logic signed [SMP_W_P-1:0] voltage_channel_i,
	input wire logic calib_scale_sel_i,
	input wire logic rate_sel_lo_i,
	input wire logic rate_sel_hi_i,
	output logic calib_pulse_out_o,
	output logic avg_pulse_out_a_n_o,
	output logic avg_pulse_out_b_n_o,
	output logic active_o
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [11:0] sup_s1_ff, sup_s2_ff;
	logic [2:0] sel_s1_ff, sel_s2_ff;
	logic signed [SMP_W_P-1:0] cur_s1_ff, cur_s2_ff, vol_s1_ff, vol_s2_ff;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sup_s1_ff <= 12'h000;
			sup_s2_ff <= 12'h000;
			sel_s1_ff <= 3'h0;
			sel_s2_ff <= 3'h0;
			cur_s1_ff <= '0;
			cur_s2_ff <= '0;
			vol_s1_ff <= '0;
			vol_s2_ff <= '0;
		end else begin
			sup_s1_ff <= supply_level_i;
			sup_s2_ff <= sup_s1_ff;
			sel_s1_ff <= {calib_scale_sel_i, rate_sel_hi_i, rate_sel_lo_i};
			sel_s2_ff <= sel_s1_ff;
			cur_s1_ff <= current_channel_i;
			cur_s2_ff <= cur_s1_ff;
			vol_s1_ff <= voltage_channel_i;
			vol_s2_ff <= vol_s1_ff;
		end
	end

	// ------------------------------------------------------------
	// supply monitor
	// ------------------------------------------------------------
	logic active_ff;
	logic [7:0] filt_ff;
	logic [7:0] nxt_filt;
	// hysteresis: different thresholds for on and off
	wire sup_wants = active_ff ? (sup_s2_ff >= SUP_OFF_LVL)
		: (sup_s2_ff >= SUP_ON_LVL);
	// filter: the opposite decision must hold FILT_P cycles in a row
	wire sup_flip = (sup_wants != active_ff)
		&& (filt_ff == 8'(FILT_P - 1));
	assign nxt_filt = (sup_wants == active_ff) ? 8'h00
		: (sup_flip ? 8'h00 : filt_ff + 8'h01);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			active_ff <= 1'b0;
			filt_ff <= 8'h00;
		end else begin
			active_ff <= sup_flip ? sup_wants : active_ff;
			filt_ff <= nxt_filt;
		end
	end

	// ------------------------------------------------------------
	// sample strobe
	// ------------------------------------------------------------
	logic [7:0] div_ff;
	// ceiling divide: the strobe runs slightly slow, never fast
	wire tick = (div_ff == 8'(SMP_DIV - 1));
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			div_ff <= 8'h00;
		else
			div_ff <= tick ? 8'h00 : div_ff + 8'h01;
	end

	// ------------------------------------------------------------
	// high-pass on current, phase match on voltage
	// ------------------------------------------------------------
	logic signed [SMP_W_P+HPF_SHIFT:0] hpf_ff;
	logic signed [SMP_W_P-1:0] vdly_ff;
	// dc estimate tracks slowly; subtracting it leaves ac content
	wire signed [SMP_W_P:0] hpf_dc = (SMP_W_P+1)'(hpf_ff >>> HPF_SHIFT);
	wire signed [SMP_W_P:0] cur_hp = cur_s2_ff - hpf_dc;
	// one-pole hpf leads by about fc/f; a one-sample voltage lag
	// spreads that over the band instead of cancelling exactly
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hpf_ff <= '0;
			vdly_ff <= '0;
		end else if (tick) begin
			hpf_ff <= hpf_ff + (SMP_W_P+HPF_SHIFT+1)'(cur_hp);
			vdly_ff <= vol_s2_ff;
		end
	end

	// ------------------------------------------------------------
	// multiplier and low-pass
	// ------------------------------------------------------------
	wire signed [2*SMP_W_P:0] prod = cur_hp * vdly_ff;
	logic signed [PWR_W+LPF_SHIFT-1:0] lpf_ff;
	wire signed [PWR_W-1:0] pwr = PWR_W'(lpf_ff >>> LPF_SHIFT);
	wire signed [PWR_W+LPF_SHIFT-1:0] lpf_step =
		(PWR_W+LPF_SHIFT)'(prod) - (PWR_W+LPF_SHIFT)'(pwr);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			lpf_ff <= '0;
		else if (tick)
			lpf_ff <= lpf_ff + lpf_step;
	end

	// ------------------------------------------------------------
	// threshold selection
	// ------------------------------------------------------------
	function automatic logic [5:0] cal_shift(input logic [2:0] s);
		// multiple = 2^(7 - rate), halved with scale low, top = 2048
		logic [5:0] r;
		r = 6'(7 - {4'h0, s[1:0]});
		if (s == 3'b011)
			r = 6'd11;
		else if (!s[2])
			r = r - 6'd1;
		return r;
	endfunction
	wire [5:0] avg_exp = 6'(THR_BASE - {4'h0, sel_s2_ff[1:0]});
	wire [5:0] cal_exp = avg_exp - cal_shift(sel_s2_ff);
	wire [ACC_W-1:0] avg_thr = ACC_W'(1) << avg_exp;
	wire [ACC_W-1:0] cal_thr = ACC_W'(1) << cal_exp;

	// ------------------------------------------------------------
	// accumulators
	// ------------------------------------------------------------
	// negative power is clipped; reverse flow makes no pulses
	wire [ACC_W-1:0] pos_pwr = pwr[PWR_W-1] ? '0 : ACC_W'(pwr);
	logic [ACC_W-1:0] avg_acc_ff, cal_acc_ff;
	wire [ACC_W-1:0] avg_sum = avg_acc_ff + pos_pwr;
	wire [ACC_W-1:0] cal_sum = cal_acc_ff + pos_pwr;
	// crossings in a live pulse are dropped; remainder still carries
	wire avg_hit = tick && active_ff && (avg_sum >= avg_thr);
	wire cal_hit = tick && active_ff && (cal_sum >= cal_thr);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			avg_acc_ff <= '0;
			cal_acc_ff <= '0;
		end else if (!active_ff) begin
			avg_acc_ff <= '0;
			cal_acc_ff <= '0;
		end else if (tick) begin
			avg_acc_ff <= avg_hit ? avg_sum - avg_thr : avg_sum;
			cal_acc_ff <= cal_hit ? cal_sum - cal_thr : cal_sum;
		end
	end

	// ------------------------------------------------------------
	// output shaping
	// ------------------------------------------------------------
	ptp_pulse_if avg_if();
	ptp_pulse_if cal_if();
	logic avg_turn_ff;
	assign avg_if.fire = avg_hit;
	assign avg_if.width = 16'(AVG_PULSE_SMP);
	assign cal_if.fire = cal_hit;
	assign cal_if.width = 16'(CAL_PULSE_SMP);
	ptp_pulse_gen u_avg_gen (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(tick),
		.enable_i(active_ff),
		.pls(avg_if)
	);
	ptp_pulse_gen u_cal_gen (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(tick),
		.enable_i(active_ff),
		.pls(cal_if)
	);
	// averaged quanta alternate between the two outputs (stepper drive)
	wire turn_flip = avg_hit && !avg_if.active;
	wire avg_a_on = avg_if.active && avg_turn_ff;
	wire avg_b_on = avg_if.active && !avg_turn_ff;
	// the gate term drops a live pulse at once on supply loss
	wire cal_on = cal_if.active && active_ff;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			avg_turn_ff <= 1'b0;
			avg_pulse_out_a_n_o <= 1'b1;
			avg_pulse_out_b_n_o <= 1'b1;
			calib_pulse_out_o <= 1'b0;
			active_o <= 1'b0;
		end else begin
			if (turn_flip)
				avg_turn_ff <= !avg_turn_ff;
			avg_pulse_out_a_n_o <= !avg_a_on;
			avg_pulse_out_b_n_o <= !avg_b_on;
			calib_pulse_out_o <= cal_on;
			active_o <= active_ff;
		end
	end

	// ------------------------------------------------------------
	// check helpers
	// ------------------------------------------------------------
	// sample ticks seen while the calibration output stands high
	logic [15:0] cal_ticks_ff;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			cal_ticks_ff <= 16'h0000;
		else if (!calib_pulse_out_o)
			cal_ticks_ff <= 16'h0000;
		else
			cal_ticks_ff <= cal_ticks_ff + 16'(tick);
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_idle_when_low: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!active_ff |=> ##1 (calib_pulse_out_o == 1'b0))
		else $error("calibration pulse while inactive");
	a_avg_idle_low: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!active_ff [*3] |-> avg_pulse_out_a_n_o && avg_pulse_out_b_n_o)
		else $error("averaged pulse while inactive");
	a_hyst_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$changed(active_ff) |-> $past(filt_ff) == 8'(FILT_P - 1))
		else $error("supply state flipped without filter");
	a_not_both_low: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!(!avg_pulse_out_a_n_o && !avg_pulse_out_b_n_o))
		else $error("both averaged outputs low");
	a_top_multiple: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sel_s2_ff == 3'b011 |-> avg_exp - cal_exp == 6'd11)
		else $error("top multiple is not 2048");
	a_cal_faster: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cal_exp < avg_exp && cal_exp >= avg_exp - 6'd11)
		else $error("calibration period out of range");
	a_scale_half: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sel_s2_ff[2] |-> avg_exp - cal_exp == 6'(7 - sel_s2_ff[1:0]))
		else $error("scale high multiple wrong");
	a_remainder: assert property (
		@(posedge clk_i) disable iff (rst_i)
		avg_hit |=> avg_acc_ff == $past(avg_sum) - $past(avg_thr))
		else $error("accumulator remainder lost");
	a_hp_no_dc: assert property (
		@(posedge clk_i) disable iff (rst_i)
		tick |=> hpf_ff == $past(hpf_ff) + $past(cur_hp))
		else $error("high-pass state not updated");

	a_acc_clear: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!active_ff |=> avg_acc_ff == '0 && cal_acc_ff == '0)
		else $error("accumulators kept while inactive");
	a_cal_remainder: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cal_hit |=> cal_acc_ff == $past(cal_sum) - $past(cal_thr))
		else $error("calibration remainder lost");
	a_lpf_step: assert property (
		@(posedge clk_i) disable iff (rst_i)
		tick |=> lpf_ff == $past(lpf_ff) + $past(lpf_step))
		else $error("low-pass state not updated");
	a_volt_delay: assert property (
		@(posedge clk_i) disable iff (rst_i)
		tick |=> vdly_ff == $past(vol_s2_ff))
		else $error("voltage delay not one sample");
	a_turn_toggle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		turn_flip |=> avg_turn_ff != $past(avg_turn_ff))
		else $error("averaged quanta did not alternate");
	a_active_out: assert property (
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> active_o == $past(active_ff))
		else $error("active output not registered state");
	a_filt_restart: assert property (
		@(posedge clk_i) disable iff (rst_i)
		sup_wants == active_ff |=> filt_ff == 8'h00)
		else $error("supply filter not restarted");
	a_cal_width: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(calib_pulse_out_o) && active_ff
		|-> cal_ticks_ff == 16'(CAL_PULSE_SMP))
		else $error("calibration pulse width wrong");
	a_neg_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		tick && active_ff && pwr[PWR_W-1] |=> cal_acc_ff <= $past(cal_acc_ff))
		else $error("accumulator grew on negative power");
	a_tick_spacing: assert property (
		@(posedge clk_i) disable iff (rst_i)
		tick |=> !tick)
		else $error("sample strobe too close");
	c_cal_pulse: cover property (@(posedge clk_i) $rose(calib_pulse_out_o));
	c_avg_a: cover property (@(posedge clk_i) $fell(avg_pulse_out_a_n_o));
	c_avg_b: cover property (@(posedge clk_i) $fell(avg_pulse_out_b_n_o));
	c_power_down: cover property (@(posedge clk_i) $fell(active_ff));
	c_hit_dropped: cover property (@(posedge clk_i) cal_hit && cal_if.active);
endmodule

//--- ptp_mcu_model.sv
// controller-side pulse counter watching the converter outputs
`timescale 1ns/1ps
module ptp_mcu_model (
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic win_i,
	input wire logic cal_i,
	input wire logic avg_a_n_i,
	input wire logic avg_b_n_i,
	output logic [31:0] cal_cnt_o,
	output logic [31:0] avg_cnt_o,
	output logic [31:0] width_o
);
	logic cal_ff;
	logic a_ff;
	logic b_ff;
	logic [31:0] run_ff;
	wire cal_rise = cal_i && !cal_ff;
	wire avg_fall = (a_ff && !avg_a_n_i) || (b_ff && !avg_b_n_i);
	// edges summed over the timed window; width_o times single calibration pulses
	always_ff @(posedge clk_i) begin
		cal_ff <= cal_i;
		a_ff <= avg_a_n_i;
		b_ff <= avg_b_n_i;
		run_ff <= cal_i ? run_ff + 32'h1 : 32'h0;
		if (cal_ff && !cal_i) begin
			width_o <= run_ff;
		end
		// one pulse of slack per window is left to the caller
		if (clr_i) begin
			cal_cnt_o <= 32'h0;
			avg_cnt_o <= 32'h0;
		end else if (win_i) begin
			cal_cnt_o <= cal_cnt_o + {31'h0, cal_rise};
			avg_cnt_o <= avg_cnt_o + {31'h0, avg_fall};
		end
	end
endmodule

//--- testbench.sv
// self-checking bench for the power to pulse converter
`timescale 1ns/1ps
module testbench;
	import ptp_pkg::*;
	localparam int FILT = 4;
	localparam int CALW = CAL_PULSE_SMP * SMP_DIV;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] sup = 12'h000;
	logic signed [15:0] cur = 16'sh0000;
	logic signed [15:0] vol = 16'sh0000;
	logic calib_scale_sel = 1'b0;
	logic [1:0] rsel = 2'b11;
	logic win = 1'b0;
	logic clr = 1'b1;
	logic cal, fa_n, fb_n, act;
	logic [31:0] cal_cnt, avg_cnt, cal_w;
	int miscompares = 0;
	int n_checks = 0;
	int c_top;
	ptp_core #(.FILT_P(FILT)) i_ptp_core (.clk_i(clk_i), .rst_i(rst_i),
		.supply_level_i(sup), .current_channel_i(cur),
		.voltage_channel_i(vol), .calib_scale_sel_i(calib_scale_sel),
		.rate_sel_lo_i(rsel[0]), .rate_sel_hi_i(rsel[1]),
		.calib_pulse_out_o(cal), .avg_pulse_out_a_n_o(fa_n),
		.avg_pulse_out_b_n_o(fb_n), .active_o(act));
	ptp_mcu_model i_ptp_mcu_model (.clk_i(clk_i), .clr_i(clr), .win_i(win),
		.cal_i(cal), .avg_a_n_i(fa_n), .avg_b_n_i(fb_n),
		.cal_cnt_o(cal_cnt), .avg_cnt_o(avg_cnt), .width_o(cal_w));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic cyc(int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic chk_bit(string nm, logic e, logic g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_vec(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic t_idle();
		@(negedge clk_i);
		chk_bit("cal_idle", 1'b0, cal);
		chk_bit("avg_a_idle", 1'b1, fa_n);
		chk_bit("avg_b_idle", 1'b1, fb_n);
		chk_bit("active", 1'b0, act);
	endtask
	task automatic t_noise();
		for (int i = 0; i < 60; i++) begin
			@(posedge clk_i);
			sup <= (i % 2 == 1) ? 12'h400 : 12'h3FF;
		end
		@(negedge clk_i);
		chk_bit("noise_active", 1'b0, act);
	endtask
	task automatic t_wake();
		int n;
		n = 0;
		@(posedge clk_i);
		sup <= 12'h400;
		while (act !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		chk_bit("wake", 1'b1, act);
		chk_bit("wake_time", 1'b1, n > FILT && n < FILT + 6);
	endtask
	task automatic t_hyst();
		@(posedge clk_i);
		sup <= 12'h3E0;
		cyc(50);
		@(negedge clk_i);
		chk_bit("hyst_active", 1'b1, act);
	endtask
	// square-wave load, 20 ticks per half period; reset clears accumulators
	task automatic run_power(logic s, logic [1:0] r, logic neg,
		output logic [31:0] cnt);
		logic ph;
		@(posedge clk_i);
		rst_i <= 1'b1;
		clr <= 1'b1;
		calib_scale_sel <= s;
		rsel <= r;
		sup <= 12'h000;
		cyc(2);
		rst_i <= 1'b0;
		t_wake();
		@(posedge clk_i);
		clr <= 1'b0;
		win <= 1'b1;
		for (int i = 0; i < 30000; i++) begin
			ph = ((i / (20 * SMP_DIV)) % 2) == 1;
			cur <= ph ? 16'sh8001 : 16'sh7FFF;
			vol <= (ph ^ neg) ? 16'sh8001 : 16'sh7FFF;
			@(posedge clk_i);
		end
		win <= 1'b0;
		@(negedge clk_i);
		cnt = cal_cnt;
	endtask
	task automatic t_top();
		logic [31:0] c;
		run_power(1'b0, 2'b11, 1'b0, c);
		c_top = c;
		chk_bit("cal_pulses", 1'b1, c > 0);
		chk_bit("cal_width", 1'b1, cal_w + 2 >= CALW && cal_w <= CALW + 2);
		chk_vec("avg_quiet", 32'h0, avg_cnt);
	endtask
	task automatic t_drop();
		int n;
		n = 0;
		@(posedge clk_i);
		sup <= 12'h3BF;
		while (act !== 1'b0 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		cyc(2);
		t_idle();
	endtask
	task automatic t_scale();
		logic [31:0] c;
		run_power(1'b1, 2'b00, 1'b0, c);
		chk_bit("scale_order", 1'b1, c < c_top);
	endtask
	task automatic t_neg();
		logic [31:0] c;
		run_power(1'b0, 2'b11, 1'b1, c);
		chk_vec("neg_pulses", 32'h0, c);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		cyc(16);
		t_idle();
		@(posedge clk_i);
		rst_i <= 1'b0;
		t_noise();
		t_wake();
		t_hyst();
		t_top();
		t_drop();
		t_scale();
		t_neg();
		close_out();
	end
	// three loaded runs of 30k cycles plus setup, under 100k in all
	initial begin
		cyc(98000);
		miscompares++;
		close_out();
	end
endmodule
